// file: logic/ldp_pkg.sv
// Shared constants for the reduced-latency memory PHY and its controller
package ldp_pkg;
  // ****************************************
  // Widths
  // ****************************************
  localparam int ADDR_W = 20; // Memory address width
  localparam int BANK_W = 4; // Bank address width
  localparam int DATA_W = 16; // Data bus width
  localparam int MASK_W = 2; // Write mask width
  localparam int LAT_W = 6; // Latency report width
  localparam int RM_W = 2; // Rank multiply width
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ = 100; // Core clock rate
  localparam int CAL_TIME_NS = 2000; // Calibration window length
  localparam int CAL_CYC = CAL_TIME_NS * CLK_MHZ / 1000; // Calibration cycles
  localparam int CAL_MIN_EDGES = 4; // Read clock edges needed to pass
  localparam logic [LAT_W-1:0] RD_LAT = 6'h0A; // Read command to valid
  localparam logic [LAT_W-1:0] WR_LAT = 6'h03; // Write command to data
  localparam int RST_REQ_MIN = 2; // Least reset request width
  // ****************************************
  // Controller register map
  // ****************************************
  localparam logic [7:0] REG_CTRL = 8'h00; // Recal and reset request
  localparam logic [7:0] REG_STATUS = 8'h04; // Calibration and latency status
  localparam logic [7:0] REG_IRQ_STAT = 8'h08; // Sticky events, write one clears
  localparam logic [7:0] REG_IRQ_MASK = 8'h0C; // Event enables
  localparam logic [7:0] REG_ADDR = 8'h10; // Address, bank, rank
  localparam logic [7:0] REG_WDATA = 8'h14; // Write data and mask
  localparam logic [7:0] REG_CMD = 8'h18; // Command launch
  localparam logic [7:0] REG_RDATA = 8'h1C; // Last read data
  // Field positions
  localparam int CTRL_RECAL = 0; // Recalibrate request bit
  localparam int CTRL_RESET = 1; // Interface reset request bit
  localparam int CMD_WRITE = 0; // Write command bit
  localparam int CMD_READ = 1; // Read command bit
  localparam int CMD_REFRESH = 2; // Refresh command bit
  localparam int ADDR_BANK = 20; // Bank field base
  localparam int ADDR_RANK = 24; // Rank field bit
  localparam int WDATA_MASK = 16; // Mask field base
  localparam int ST_SUCCESS = 0; // Status success bit
  localparam int ST_FAIL = 1; // Status fail bit
  localparam int ST_RDONE = 2; // Status reset done bit
  localparam int ST_BUSY = 3; // Status busy bit
  localparam int ST_RLAT = 8; // Read latency field
  localparam int ST_WLAT = 16; // Write latency field
  localparam int IRQ_OK = 0; // Calibration passed event
  localparam int IRQ_FAIL = 1; // Calibration failed event
  localparam int IRQ_RD = 2; // Read data returned event
  localparam int IRQ_REFUSED = 3; // Command refused event
  localparam int IRQ_W = 4; // Event count
endpackage

// file: logic/ldp_link_if.sv
// Controller-to-PHY command, data and status link
`timescale 1ns/100ps
interface ldp_link_if;
  import ldp_pkg::*;
  logic cal_success; // Calibration passed
  logic cal_fail; // Calibration failed
  logic cal_req; // Recalibrate request
  logic [LAT_W-1:0] rd_lat; // Read latency in cycles
  logic [LAT_W-1:0] wr_lat; // Write latency in cycles
  logic [ADDR_W-1:0] addr; // Address
  logic [BANK_W-1:0] bank; // Bank address
  logic cs_n; // Chip select, low active
  logic we_n; // Write command, low active
  logic ref_n; // Refresh command, low active
  logic [MASK_W-1:0] ctrl_write_mask; // Write mask
  logic wdata_valid; // Write data qualifier
  logic [DATA_W-1:0] wdata; // Write data
  logic rdata_en; // Read data expected
  logic [DATA_W-1:0] rdata; // Read data
  logic rdata_valid; // Read data qualifier
  logic rrank; // Read rank
  logic wrank; // Write rank
  logic link_reset_n; // Link domain reset
  logic half_clk; // Half-rate clock
  logic reset_req; // Interface reset request
  logic reset_done; // Reset sequence finished
  modport phy (output cal_success, cal_fail, rd_lat, wr_lat, rdata, rdata_valid,
    link_reset_n, half_clk, reset_done,
    input cal_req, addr, bank, cs_n, we_n, ref_n, ctrl_write_mask, wdata_valid,
    wdata, rdata_en, rrank, wrank, reset_req);
  modport mc (input cal_success, cal_fail, rd_lat, wr_lat, rdata, rdata_valid,
    link_reset_n, half_clk, reset_done,
    output cal_req, addr, bank, cs_n, we_n, ref_n, ctrl_write_mask, wdata_valid,
    wdata, rdata_en, rrank, wrank, reset_req);
endinterface

// file: logic/ldp_phy.sv
// PHY end: calibration, latency report, command forwarding and memory pins
//
// Chosen here: the register offsets and register access over Wishbone.
`timescale 1ns/100ps
// Notes on behaviour
// - Link reset asserts at once, releases clocked
// - Half-rate clock toggles every core cycle
// - Report read latency in core cycles
// - Report write latency in core cycles
// - Recalibration request restarts calibration
// - Separate link success and fail outputs
// - User-visible success and fail status levels
// - Controller flags valid write data exactly
// - Read valid marks exactly valid read data
// - Controller read enable announces expected data
// - Rank hints switch per-rank shadow settings
// - Forward address, bank, selects, commands, mask
// - Drive command/write clocks, sample read clock
// - Two-bit rank multiply output for buffers
// - Extra clocks need proper domain crossing
// - Debug reset released synchronous to debug clock; this PHY has no debug clock or debug reset
// - Reset request held high two cycles
// - Reset done high when ready, low in reset
module ldp_phy #(
  parameter int CK_HALF = 2, // Core cycles per memory clock half period
  parameter int CAL_CYCLES = ldp_pkg::CAL_CYC, // Calibration window
  parameter bit LR_MODULE = 1'b1 // Load-reduced module fitted
) (
  input wire logic clk_i, // Core clock
  input wire logic rst_i, // Synchronous reset, high
  ldp_link_if.phy link, // Controller side
  output logic memory_command_clock_o, // Command clock, true leg
  output logic memory_command_clock_n_o, // Command clock, negative leg
  output logic memory_write_clock_o, // Write clock, true leg
  output logic memory_write_clock_n_o, // Write clock, negative leg
  input wire logic memory_read_clock_i, // Read clock, true leg
  input wire logic memory_read_clock_n_i, // Read clock, negative leg
  output logic [ldp_pkg::ADDR_W-1:0] mem_addr_o, // Address
  output logic [ldp_pkg::BANK_W-1:0] mem_bank_o, // Bank address
  output logic mem_cs_n_o, // Chip select
  output logic mem_we_n_o, // Write command
  output logic mem_ref_n_o, // Refresh command
  output logic mem_reset_n_o, // Memory reset
  output logic [ldp_pkg::MASK_W-1:0] memory_write_mask_o, // Write mask
  output logic [ldp_pkg::DATA_W-1:0] mem_dq_o, // Data out
  output logic mem_dq_oe_o, // Data drive enable
  input wire logic [ldp_pkg::DATA_W-1:0] mem_dq_i, // Data in
  output logic [ldp_pkg::RM_W-1:0] rank_multiply_out_o, // Extra buffer selects
  output logic [ldp_pkg::LAT_W-1:0] shadow_trim_o, // Active rank trim
  output logic cal_success_o, // User status: passed
  output logic cal_fail_o // User status: failed
);
  import ldp_pkg::*;

  // Divider and window counters are 8 and 16 bits, larger settings would wrap
  if (CK_HALF < 1 || CK_HALF > 256 || CAL_CYCLES < 2 || CAL_CYCLES > 65536 || RD_LAT < 3) begin
    $error("ldp_phy: parameter out of range");
  end

  typedef enum logic [3:0] {
    CAL_RESET = 4'b0001,
    CAL_RUN = 4'b0010,
    CAL_PASS = 4'b0100,
    CAL_FAILED = 4'b1000
  } ldp_cal_e;

  // ****************************************
  // Reset request and link reset
  // ****************************************
  logic [1:0] req_sync; // Request synchroniser
  logic [1:0] rel_pipe; // Release pipeline
  logic in_reset; // Internal reset level

  // Request may come from another domain, so it is synchronised first
  always_ff @(posedge clk_i) begin
    req_sync <= {req_sync[0], link.reset_req};
  end

  assign in_reset = rst_i | req_sync[1];

  // Assert on the same edge as the cause, release two edges later
  always_ff @(posedge clk_i) begin
    if (in_reset) begin
      rel_pipe <= 2'h0;
    end else begin
      rel_pipe <= {rel_pipe[0], 1'b1};
    end
  end

  always_ff @(posedge clk_i) begin
    link.link_reset_n <= rel_pipe[1] & ~in_reset;
    mem_reset_n_o <= rel_pipe[1] & ~in_reset;
    link.reset_done <= rel_pipe[1] & ~in_reset;
  end

  // ****************************************
  // Half-rate clock
  // ****************************************
  // Kept as a data-path toggle: a single clock tree feeds the whole block
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link.half_clk <= 1'b0;
    end else begin
      link.half_clk <= ~link.half_clk;
    end
  end

  // ****************************************
  // Memory clock divider
  // ****************************************
  logic [7:0] ck_cnt; // Divider count
  logic ck_lvl; // Divided clock level

  always_ff @(posedge clk_i) begin
    if (rst_i || ck_cnt == 8'(CK_HALF - 1)) begin
      ck_cnt <= 8'h00;
    end else begin
      ck_cnt <= ck_cnt + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ck_lvl <= 1'b0;
    end else if (ck_cnt == 8'(CK_HALF - 1)) begin
      ck_lvl <= ~ck_lvl;
    end
  end

  // Both pairs come straight from flip-flops, complements in step
  always_ff @(posedge clk_i) begin
    memory_command_clock_o <= ck_lvl;
    memory_command_clock_n_o <= ~ck_lvl;
    memory_write_clock_o <= ck_lvl;
    memory_write_clock_n_o <= ~ck_lvl;
  end

  // ****************************************
  // Read clock sampling
  // ****************************************
  logic [1:0] qk_sync; // True leg synchroniser
  logic [1:0] qkn_sync; // Negative leg synchroniser
  logic qk_last; // Previous synchronised level
  logic qk_rise; // Qualified rising edge

  always_ff @(posedge clk_i) begin
    qk_sync <= {qk_sync[0], memory_read_clock_i};
    qkn_sync <= {qkn_sync[0], memory_read_clock_n_i};
    qk_last <= qk_sync[1];
  end

  // An edge only counts while the legs disagree, filtering a stuck pair
  assign qk_rise = qk_sync[1] & ~qk_last & ~qkn_sync[1];

  // ****************************************
  // Calibration sequencer
  // ****************************************
  ldp_cal_e cal_st; // Sequencer state
  ldp_cal_e next_cal_st; // Next state
  logic [15:0] cal_cnt; // Window counter
  logic [7:0] edge_cnt; // Edges seen in window
  logic cal_end; // Window over

  assign cal_end = cal_cnt == 16'(CAL_CYCLES - 1);

  always_comb begin
    next_cal_st = cal_st;
    case (cal_st)
      CAL_RESET: next_cal_st = CAL_RUN; // Leave reset into calibration
      CAL_RUN: begin
        if (cal_end) begin
          next_cal_st = (edge_cnt >= 8'(CAL_MIN_EDGES)) ? CAL_PASS : CAL_FAILED;
        end
      end
      CAL_PASS, CAL_FAILED: begin
        if (link.cal_req) begin
          next_cal_st = CAL_RUN;
        end
      end
      default: next_cal_st = CAL_RESET;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (in_reset) begin
      cal_st <= CAL_RESET;
    end else begin
      cal_st <= next_cal_st;
    end
  end

  // Counters restart at every entry into the window
  always_ff @(posedge clk_i) begin
    if (cal_st != CAL_RUN) begin
      cal_cnt <= 16'h0000;
      edge_cnt <= 8'h00;
    end else begin
      cal_cnt <= cal_cnt + 16'h0001;
      if (qk_rise && edge_cnt != 8'hFF) begin
        edge_cnt <= edge_cnt + 8'h01;
      end
    end
  end

  // One-hot state keeps the two flags exclusive
  always_ff @(posedge clk_i) begin
    link.cal_success <= next_cal_st == CAL_PASS && !in_reset;
    link.cal_fail <= next_cal_st == CAL_FAILED && !in_reset;
    cal_success_o <= next_cal_st == CAL_PASS && !in_reset;
    cal_fail_o <= next_cal_st == CAL_FAILED && !in_reset;
  end

  // ****************************************
  // Latency report
  // ****************************************
  always_ff @(posedge clk_i) begin
    link.rd_lat <= RD_LAT;
    link.wr_lat <= WR_LAT;
  end

  // ****************************************
  // Per-rank shadow settings
  // ****************************************
  logic [LAT_W-1:0] trim [2]; // Per-rank trim values
  logic act_rank; // Rank currently selected

  // Each rank keeps the edge count of its last calibration window, pass or fail, as a trim value
  for (genvar r = 0; r < 2; r++) begin : g_rank
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        trim[r] <= '0;
      end else if (cal_st == CAL_RUN && cal_end && act_rank == 1'(r)) begin
        trim[r] <= edge_cnt[LAT_W-1:0];
      end
    end
  end

  // A read hint wins over a write hint in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      act_rank <= 1'b0;
    end else if (link.rdata_en) begin
      act_rank <= link.rrank;
    end else if (link.wdata_valid) begin
      act_rank <= link.wrank;
    end
  end

  always_ff @(posedge clk_i) begin
    shadow_trim_o <= trim[act_rank];
    rank_multiply_out_o <= LR_MODULE ? {1'b0, act_rank} : '0;
  end

  // ****************************************
  // Command and write forwarding
  // ****************************************
  // Idle values are driven while in reset so the memory sees no command
  always_ff @(posedge clk_i) begin
    if (in_reset) begin
      mem_cs_n_o <= 1'b1;
      mem_we_n_o <= 1'b1;
      mem_ref_n_o <= 1'b1;
      mem_addr_o <= '0;
      mem_bank_o <= '0;
      memory_write_mask_o <= '0;
    end else begin
      mem_cs_n_o <= link.cs_n;
      mem_we_n_o <= link.we_n;
      mem_ref_n_o <= link.ref_n;
      mem_addr_o <= link.addr;
      mem_bank_o <= link.bank;
      memory_write_mask_o <= link.ctrl_write_mask;
    end
  end

  // Data pins are driven only in cycles flagged by the controller
  always_ff @(posedge clk_i) begin
    mem_dq_oe_o <= link.wdata_valid & ~in_reset;
    mem_dq_o <= link.wdata;
  end

  // ****************************************
  // Read return path
  // ****************************************
  logic [RD_LAT-1:0] rd_pipe; // Read enable delay line
  logic [DATA_W-1:0] dq_s1; // Data synchroniser, first stage
  logic [DATA_W-1:0] dq_s2; // Data synchroniser, second stage

  always_ff @(posedge clk_i) begin
    dq_s1 <= mem_dq_i;
    dq_s2 <= dq_s1;
  end

  // Last stage is registered below, so the pipe is one short of RD_LAT
  always_ff @(posedge clk_i) begin
    if (in_reset || cal_st != CAL_PASS) begin
      rd_pipe <= '0;
    end else begin
      rd_pipe <= {rd_pipe[RD_LAT-2:0], link.rdata_en};
    end
  end

  always_ff @(posedge clk_i) begin
    link.rdata_valid <= rd_pipe[RD_LAT-2];
    link.rdata <= rd_pipe[RD_LAT-2] ? dq_s2 : '0;
  end
endmodule

// file: logic/ldp_ctrl.sv
// Controller end: Wishbone registers driving the PHY link
`timescale 1ns/100ps
module ldp_ctrl (
  input wire logic clk_i, // Core clock
  input wire logic rst_i, // Synchronous reset, high
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Bus strobe
  input wire logic wb_we_i, // Write enable
  input wire logic [7:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte lanes
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  output logic irq_o, // Level interrupt
  ldp_link_if.mc link // PHY side
);
  import ldp_pkg::*;

  typedef enum logic [2:0] {
    MC_IDLE = 3'b001,
    MC_WLAT = 3'b010,
    MC_RWAIT = 3'b100
  } ldp_mc_e;

  // ****************************************
  // Bus decode
  // ****************************************
  logic req; // New access this cycle
  logic wr; // New write this cycle
  logic [31:0] wmsk; // Byte-lane write mask

  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = req & wb_we_i;
  for (genvar b = 0; b < 4; b++) begin : g_sel
    assign wmsk[8*b +: 8] = {8{wb_sel_i[b]}};
  end

  // One wait state, ack drops in the following cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  logic [31:0] addr_r; // Address, bank and rank
  logic [31:0] wdata_r; // Write data and mask
  logic [DATA_W-1:0] rdata_r; // Last read data
  logic [IRQ_W-1:0] irq_stat; // Sticky events
  logic [IRQ_W-1:0] irq_mask; // Event enables
  logic [IRQ_W-1:0] ev; // Events this cycle
  logic ok_q; // Success one cycle ago
  logic fail_q; // Fail one cycle ago
  ldp_mc_e st; // Command sequencer state

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_r <= 32'h0000_0000;
      wdata_r <= 32'h0000_0000;
      irq_mask <= '0;
    end else if (wr) begin
      if (wb_adr_i == REG_ADDR) addr_r <= (addr_r & ~wmsk) | (wb_dat_i & wmsk);
      if (wb_adr_i == REG_WDATA) wdata_r <= (wdata_r & ~wmsk) | (wb_dat_i & wmsk);
      if (wb_adr_i == REG_IRQ_MASK && wb_sel_i[0]) irq_mask <= wb_dat_i[IRQ_W-1:0];
    end
  end

  // Read mux, unmapped offsets answer zero
  always_ff @(posedge clk_i) begin
    wb_dat_o <= 32'h0000_0000;
    if (req && !wb_we_i) begin
      case (wb_adr_i)
        REG_STATUS: begin
          wb_dat_o[ST_SUCCESS] <= link.cal_success;
          wb_dat_o[ST_FAIL] <= link.cal_fail;
          wb_dat_o[ST_RDONE] <= link.reset_done;
          wb_dat_o[ST_BUSY] <= st != MC_IDLE;
          wb_dat_o[ST_RLAT +: LAT_W] <= link.rd_lat;
          wb_dat_o[ST_WLAT +: LAT_W] <= link.wr_lat;
        end
        REG_IRQ_STAT: wb_dat_o[IRQ_W-1:0] <= irq_stat;
        REG_IRQ_MASK: wb_dat_o[IRQ_W-1:0] <= irq_mask;
        REG_ADDR: wb_dat_o <= addr_r;
        REG_WDATA: wb_dat_o <= wdata_r;
        REG_RDATA: wb_dat_o[DATA_W-1:0] <= rdata_r;
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  logic launch; // Command write this cycle
  logic [2:0] cmd; // Command bits written

  assign launch = wr && wb_adr_i == REG_CMD && wb_sel_i[0];
  assign cmd = wb_dat_i[2:0];

  always_ff @(posedge clk_i) begin
    ok_q <= link.cal_success;
    fail_q <= link.cal_fail;
  end

  always_comb begin
    ev = '0;
    ev[IRQ_OK] = link.cal_success & ~ok_q;
    ev[IRQ_FAIL] = link.cal_fail & ~fail_q;
    ev[IRQ_RD] = st == MC_RWAIT && link.rdata_valid;
    ev[IRQ_REFUSED] = launch && cmd != 3'h0 && (st != MC_IDLE || !link.cal_success);
  end

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat <= '0;
    end else begin
      if (wr && wb_adr_i == REG_IRQ_STAT && wb_sel_i[0]) begin
        irq_stat <= (irq_stat & ~wb_dat_i[IRQ_W-1:0]) | ev;
      end else begin
        irq_stat <= irq_stat | ev;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    irq_o <= rst_i ? 1'b0 : |(irq_stat & irq_mask);
  end

  // ****************************************
  // Reset and recalibration requests
  // ****************************************
  logic [1:0] rst_cnt; // Request hold counter

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rst_cnt <= 2'h0;
    end else if (wr && wb_adr_i == REG_CTRL && wb_sel_i[0] && wb_dat_i[CTRL_RESET]) begin
      rst_cnt <= 2'(RST_REQ_MIN);
    end else if (rst_cnt != 2'h0) begin
      rst_cnt <= rst_cnt - 2'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    link.reset_req <= rst_cnt != 2'h0;
    link.cal_req <= wr && wb_adr_i == REG_CTRL && wb_sel_i[0] && wb_dat_i[CTRL_RECAL];
  end

  // ****************************************
  // Command sequencer
  // ****************************************
  logic [LAT_W-1:0] lat_cnt; // Write latency counter
  logic go; // Accepted command
  logic [2:0] next_cmd; // Command issued now

  // Commands only go out once calibration has passed
  assign go = launch && st == MC_IDLE && link.cal_success;
  assign next_cmd = go ? cmd : 3'h0;

  always_ff @(posedge clk_i) begin
    if (rst_i || !link.cal_success) begin
      st <= MC_IDLE;
    end else begin
      case (st)
        MC_IDLE: begin
          if (next_cmd[CMD_WRITE]) st <= MC_WLAT;
          else if (next_cmd[CMD_READ]) st <= MC_RWAIT;
        end
        MC_WLAT: if (lat_cnt == '0) st <= MC_IDLE;
        MC_RWAIT: if (link.rdata_valid) st <= MC_IDLE;
        default: st <= MC_IDLE;
      endcase
    end
  end

  // Latency counts from the command cycle, data follows in the matching cycle
  always_ff @(posedge clk_i) begin
    if (go) begin
      lat_cnt <= link.wr_lat - 6'h01;
    end else if (st == MC_WLAT && lat_cnt != '0) begin
      lat_cnt <= lat_cnt - 6'h01;
    end
  end

  // Write wins over read and refresh when several bits are set
  always_ff @(posedge clk_i) begin
    link.cs_n <= ~(next_cmd[CMD_WRITE] | next_cmd[CMD_READ] | next_cmd[CMD_REFRESH]);
    link.we_n <= ~next_cmd[CMD_WRITE];
    link.ref_n <= ~(next_cmd[CMD_REFRESH] & ~next_cmd[CMD_WRITE] & ~next_cmd[CMD_READ]);
    link.rdata_en <= next_cmd[CMD_READ] & ~next_cmd[CMD_WRITE];
    link.addr <= addr_r[ADDR_W-1:0];
    link.bank <= addr_r[ADDR_BANK +: BANK_W];
    link.rrank <= addr_r[ADDR_RANK];
    link.wrank <= addr_r[ADDR_RANK];
    link.ctrl_write_mask <= wdata_r[WDATA_MASK +: MASK_W];
    link.wdata <= wdata_r[DATA_W-1:0];
    link.wdata_valid <= !rst_i && st == MC_WLAT && lat_cnt == '0;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_r <= '0;
    end else if (st == MC_RWAIT && link.rdata_valid) begin
      rdata_r <= link.rdata;
    end
  end
endmodule

// file: testbench/ldp_chk.sv
// Link checker for the controller and PHY pair
`timescale 1ns/100ps
module ldp_chk
  import ldp_pkg::*;
(
  input wire logic clk_i, // Core clock
  input wire logic rst_i, // Reset, high
  input wire logic cal_success, // Passed
  input wire logic cal_fail, // Failed
  input wire logic cal_req, // Recalibrate
  input wire logic [LAT_W-1:0] rd_lat, // Read latency
  input wire logic [LAT_W-1:0] wr_lat, // Write latency
  input wire logic cs_n, // Select
  input wire logic we_n, // Write
  input wire logic wdata_valid, // Write data
  input wire logic rdata_en, // Read expected
  input wire logic rdata_valid, // Read data
  input wire logic half_clk, // Half clock
  input wire logic reset_req, // Reset request
  input wire logic link_reset_n, // Link reset
  input wire logic reset_done // Reset finished
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ****************************************
  // Command and reset request shapes
  // ****************************************
  sequence s_wcmd; !cs_n && !we_n; endsequence
  sequence s_rcmd; !cs_n && rdata_en; endsequence
  sequence s_rreq; reset_req [*2]; endsequence
  // Latencies are fixed, so a drifting pipe shows at once
  property p_excl; !(cal_success && cal_fail); endproperty
  property p_cmdok; !cs_n |-> cal_success; endproperty
  property p_half; link_reset_n |=> half_clk != $past(half_clk); endproperty
  property p_lat; link_reset_n |-> rd_lat == RD_LAT && wr_lat == WR_LAT; endproperty
  property p_wr; s_wcmd |-> ##3 wdata_valid; endproperty
  property p_rd; s_rcmd |-> ##10 rdata_valid; endproperty
  property p_recal; cal_req |=> !cal_success && !cal_fail; endproperty
  property p_rreq; s_rreq |-> ##[1:4] !link_reset_n && !reset_done; endproperty
  a_excl: assert property (p_excl) else $error("pass and fail flags together");
  a_cmdok: assert property (p_cmdok) else $error("command before calibration");
  a_half: assert property (p_half) else $error("half clock stalled");
  a_lat: assert property (p_lat) else $error("latency report wrong");
  a_wr: assert property (p_wr) else $error("write data late or early");
  a_rd: assert property (p_rd) else $error("read valid late or early");
  a_recal: assert property (p_recal) else $error("flags kept on recal");
  a_rreq: assert property (p_rreq) else $error("reset request ignored");
endmodule

// file: testbench/low_latency_dram_phy_ports_tb.sv
// Bench joining controller and PHY through the link
`timescale 1ns/100ps
module low_latency_dram_phy_ports_tb;
  import ldp_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, qk = 0, qk_en = 1; // Drives
  logic [7:0] adr = 8'h00; // Bus address
  logic [31:0] dat = 32'h0000_0000, q, rdo; // Bus data
  logic [15:0] dq_in = 16'hA5C3, mdq; // Memory data
  logic [19:0] ma;
  logic [3:0] mb;
  logic [1:0] mdm, rm;
  logic ack, irq, ck, ck_n, mcs, mwe, mref, moe, okq, flq;
  logic [LAT_W-1:0] trim; // Active rank trim
  int mismatches = 0, tests_run = 0, cyc_n = 0;
  wire logic [15:0] dq = moe ? mdq : dq_in; // Shared data wire
  ldp_link_if l();
  ldp_phy #(.CAL_CYCLES(100)) ldp_phy_inst (.clk_i(clk_i), .rst_i(rst_i), .link(l),
    .memory_command_clock_o(ck), .memory_command_clock_n_o(ck_n), .memory_write_clock_o(),
    .memory_write_clock_n_o(), .memory_read_clock_i(qk), .memory_read_clock_n_i(~qk),
    .mem_addr_o(ma), .mem_bank_o(mb), .mem_cs_n_o(mcs), .mem_we_n_o(mwe), .mem_ref_n_o(mref),
    .mem_reset_n_o(), .memory_write_mask_o(mdm), .mem_dq_o(mdq), .mem_dq_oe_o(moe),
    .mem_dq_i(dq), .rank_multiply_out_o(rm), .shadow_trim_o(trim), .cal_success_o(okq),
    .cal_fail_o(flq));
  ldp_ctrl ldp_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdo),
    .wb_ack_o(ack), .irq_o(irq), .link(l));
  ldp_chk ldp_chk_inst (.clk_i(clk_i), .rst_i(rst_i), .cal_success(l.cal_success),
    .cal_fail(l.cal_fail), .cal_req(l.cal_req), .rd_lat(l.rd_lat), .wr_lat(l.wr_lat),
    .cs_n(l.cs_n), .we_n(l.we_n), .wdata_valid(l.wdata_valid), .rdata_en(l.rdata_en),
    .rdata_valid(l.rdata_valid), .half_clk(l.half_clk), .reset_req(l.reset_req),
    .link_reset_n(l.link_reset_n), .reset_done(l.reset_done));
  // Core clock, and a read clock that stands still when disabled
  always #5 clk_i = ~clk_i;
  always #80 if (qk_en) qk = ~qk;
  // Cuts a hung run short
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 40000) begin
      mismatches++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Classic cycle: hold until ack is sampled, then release
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && n < 50);
    q = rdo;
    {cyc, stb} <= 2'b00;
    chk(n < 50, 1);
  endtask
  // Polls status until a bit takes a value, slow calibration tolerated
  task automatic wst(input int b, input logic v);
    int n;
    n = 0;
    do begin wb(0, REG_STATUS, 0); n++; end while (q[b] !== v && n < 600);
  endtask
  task automatic t_cal;
    wb(0, REG_IRQ_MASK, 0); chk(q, 0);
    wst(ST_SUCCESS, 1); chk(q, 32'h0003_0A05);
    chk({okq, flq, ck_n ^ ck}, 3'b101);
    wb(0, 8'h40, 0); chk(q, 0);
    wb(1, REG_IRQ_MASK, 1); repeat (3) @(posedge clk_i); chk(irq, 1);
    wb(1, REG_IRQ_STAT, 1); repeat (3) @(posedge clk_i); chk(irq, 0);
  endtask
  task automatic t_wr;
    int n;
    n = 0;
    wb(1, REG_ADDR, 32'h0151_2345); wb(1, REG_WDATA, 32'h0002_BEEF); wb(1, REG_CMD, 1);
    while (mcs !== 1'b0 && n < 20) begin @(posedge clk_i); n++; end
    chk({mwe, mdm, mb, ma}, {1'b0, 2'h2, 4'h5, 20'h1_2345});
    while (moe !== 1'b1 && n < 40) begin @(posedge clk_i); n++; end
    chk(dq, 16'hBEEF);
  endtask
  task automatic t_rd;
    dq_in <= 16'h5A3C;
    wb(1, REG_CMD, 2); repeat (20) @(posedge clk_i);
    wb(0, REG_IRQ_STAT, 0); chk(q[IRQ_RD], 1);
    wb(0, REG_RDATA, 0); chk(q[15:0], 16'h5A3C);
    chk(rm, 2'b01);
    wb(1, REG_CMD, 4);
    @(posedge clk_i);
    chk({mcs, mwe, mref}, 3'b010);
  endtask
  task automatic t_fail;
    qk_en = 0;
    wb(1, REG_CTRL, 1); wst(ST_FAIL, 1); chk(q[1:0], 2'b10);
    chk({okq, flq}, 2'b01);
    wb(1, REG_CMD, 1); wb(0, REG_IRQ_STAT, 0); chk(q[IRQ_REFUSED], 1);
  endtask
  task automatic t_rst;
    qk_en = 1;
    wb(1, REG_CTRL, 2); wst(ST_SUCCESS, 1); chk(q[2:0], 3'b101);
    chk(trim >= 6'(CAL_MIN_EDGES), 1);
  endtask
  task automatic end_sim;
    if (mismatches == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    t_cal(); t_wr(); t_rd(); t_fail(); t_rst();
    end_sim();
  end
endmodule
